/* File: hdl/bit_window.sv */
// Picks a window of consecutive bits out of a bit image, starting at an address.
// Bits past the point count read as zero.
`timescale 1ns/100ps
`default_nettype none
module bit_window
    import remote_map_pkg::*;
(
    input  wire logic [BIT_IMAGE-1:0] i_image,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [PT_W-1:0]      i_points,
    output logic [WIN_W-1:0]          o_bits
);
    genvar g;
    // Point g of the slave sits at image position address plus g
    generate
        for (g = 0; g < WIN_W; g++) begin : g_pick
            wire logic [BIT_AW-1:0] pos = BIT_AW'({1'b0, i_addr}) + BIT_AW'(g);
            assign o_bits[g] = (PT_W'(g) < i_points) ? i_image[pos] : 1'b0;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hdl/remote_io_map.sv */
// Mapper between field-bus slaves and the remote bit and word images.
// Assumes slave exchanges and host image ports are driven on i_clk.
//
// Notes on behaviour
// - A slave fills as many consecutive positions as points, upward from its address.
// - Image words hold sixteen bits; bit 0 to F equals address 0 to 15.
// - Two-point input slave at address 0 lands in input bits 0 and 1.
// - Two-point output slave at address 2 takes output bits 2 and 3.
// - One-point slave at address 2 takes only bit 2.
// - Two-point slave at address 3 takes bits 3 and 4.
// - Two-word input slave at word 0 fills input words 0 and 1.
// - Two-word output slave at word 2 reads output words 2 and 3.
// - Word slave data stored or replied only when word point setting is eight or more; host output word writes always stored.
// - Address 511 reserved for all four slave kinds, 255 for bit slaves only; 1024 mode reserves 511 only.
// - Reserved identity raises the no-ID alarm with its fixed code.
// - Identity is kind base plus address for the four slave kinds.
`timescale 1ns/100ps
`default_nettype none
module remote_io_map
    import remote_map_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Configuration
    input  wire logic                 i_mode_1024,
    input  wire logic [9:0]           i_word_points,
    // Host side images
    input  wire logic [BIT_IMAGE-1:0] i_remote_output_bits,
    output logic [BIT_IMAGE-1:0]      o_remote_input_bits,
    input  wire host_word_wr_t        i_host_word_wr,
    input  wire logic [WORD_AW-1:0]   i_host_rd_index,
    output logic [WIN_W-1:0]          o_host_rd_data,
    // Slave side
    input  wire slave_xfer_t          i_xfer,
    output slave_reply_t              o_reply,
    // Alarm
    output alarm_t                    o_alarm,
    output logic                      o_word_setting_low
);
    // Word images held here
    logic [WIN_W-1:0]      remote_output_words [WORD_DEPTH];
    logic [WIN_W-1:0]      remote_input_words  [WORD_DEPTH];

    logic [BIT_IMAGE-1:0]  input_bits;
    slave_reply_t          reply;
    alarm_t                alarm;
    logic [WIN_W-1:0]      host_rd_data;
    logic                  word_low;

    slave_kind_t           kind;
    logic [ADDR_W-1:0]     addr;
    logic                  reserved;
    logic [WIN_W-1:0]      out_window;

    // Identity decode and reserved check
    slave_id_check u_id_check (
        .i_id        (i_xfer.id),
        .i_mode_1024 (i_mode_1024),
        .o_kind      (kind),
        .o_addr      (addr),
        .o_reserved  (reserved)
    );

    // Output bits for a bit output slave, taken from its address upward
    bit_window u_out_window (
        .i_image  (i_remote_output_bits),
        .i_addr   (addr),
        .i_points (i_xfer.points),
        .o_bits   (out_window)
    );

    // Request decode
    wire logic take       = i_xfer.valid && !reserved;
    wire logic words_ok   = (i_word_points >= WORD_POINTS_MIN);
    wire logic do_bit_in  = take && (kind == KIND_BIT_IN);
    wire logic do_bit_out = take && (kind == KIND_BIT_OUT);
    wire logic do_word_in = take && (kind == KIND_WORD_IN) && words_ok;
    wire logic do_word_out = take && (kind == KIND_WORD_OUT) && words_ok;

    // Word position is start address plus the word's index in the slave
    wire logic [WORD_AW:0] word_pos = (WORD_AW+1)'({1'b0, addr})
                                    + (WORD_AW+1)'(i_xfer.word_sel);
    wire logic word_in_range = (word_pos < (WORD_AW+1)'(WORD_DEPTH));
    wire logic [WORD_AW-1:0] word_idx = word_pos[WORD_AW-1:0];

    // Fresh input bit image: each point goes to address plus its index
    logic [BIT_IMAGE-1:0] next_input_bits;
    always_comb begin
        next_input_bits = input_bits;
        if (do_bit_in) begin
            for (int k = 0; k < WIN_W; k++) begin
                if (PT_W'(k) < i_xfer.points) begin
                    next_input_bits[BIT_AW'({1'b0, addr}) + BIT_AW'(k)] = i_xfer.data[k];
                end
            end
        end
    end

    // Reply value chosen from the slave kind
    logic [WIN_W-1:0] next_reply_data;
    always_comb begin
        next_reply_data = '0;
        if (do_bit_out) begin
            next_reply_data = out_window;
        end else if (do_word_out && word_in_range) begin
            next_reply_data = remote_output_words[word_idx];
        end
    end

    // Input bit image; positions no slave has written stay zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            input_bits <= '0;
        end else begin
            input_bits <= next_input_bits;
        end
    end

    // Input word image from word input slaves
    always_ff @(posedge i_clk) begin
        if (do_word_in && word_in_range) begin
            remote_input_words[word_idx] <= i_xfer.data;
        end
    end

    // Output word image written by the host side
    always_ff @(posedge i_clk) begin
        if (i_host_word_wr.valid) begin
            remote_output_words[i_host_word_wr.index] <= i_host_word_wr.data;
        end
    end

    // Host read of the input word image, one cycle late
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            host_rd_data <= '0;
        end else begin
            host_rd_data <= remote_input_words[i_host_rd_index];
        end
    end

    // Reply to the slave on the cycle after its exchange
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            reply <= '0;
        end else begin
            reply.valid    <= i_xfer.valid;
            reply.accepted <= do_bit_in || do_bit_out || do_word_in || do_word_out;
            reply.data     <= next_reply_data;
        end
    end

    // No-ID alarm pulse with its code and the offending identity
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            alarm <= '0;
        end else begin
            alarm.valid <= i_xfer.valid && reserved;
            alarm.code  <= ALARM_NO_ID;
            alarm.id    <= i_xfer.id;
        end
    end

    // Word setting too small to hold word slave data
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            word_low <= 1'b0;
        end else begin
            word_low <= !words_ok;
        end
    end

    assign o_remote_input_bits = input_bits;
    assign o_reply             = reply;
    assign o_alarm             = alarm;
    assign o_host_rd_data      = host_rd_data;
    assign o_word_setting_low  = word_low;
endmodule
`default_nettype wire

/* File: hdl/slave_id_check.sv */
// Splits a slave identity into kind and start address and flags reserved ones.
// Purely combinational; used by the mapper on every slave exchange.
`timescale 1ns/100ps
`default_nettype none
module slave_id_check
    import remote_map_pkg::*;
(
    input  wire logic [ID_W-1:0]   i_id,
    input  wire logic              i_mode_1024,
    output slave_kind_t            o_kind,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_reserved
);
    wire logic is_bit   = (o_kind == KIND_BIT_OUT) || (o_kind == KIND_BIT_IN);
    wire logic hit_high = (o_addr == RSV_ADDR_HIGH);
    wire logic hit_low  = (o_addr == RSV_ADDR_LOW);

    // Kind sits above the address, base plus address forms the identity
    assign o_kind     = slave_kind_t'(i_id[ID_W-1:ID_KIND_LSB]);
    assign o_addr     = i_id[ADDR_W-1:0];
    // Low reserved address applies to bit slaves only below 1024 points
    assign o_reserved = hit_high || (is_bit && !i_mode_1024 && hit_low);
endmodule
`default_nettype wire

/* File: shared/remote_map_pkg.sv */
// Constants and carrier types for the slave address to remote image mapper.
// Assumes one clock domain shared by the host side and the slave link side.
package remote_map_pkg;

    // Image sizes
    localparam int BIT_IMAGE  = 1024;
    localparam int BIT_AW     = 10;
    localparam int WORD_DEPTH = 512;
    localparam int WORD_AW    = 9;
    localparam int ADDR_W     = 9;
    localparam int ID_W       = 11;
    localparam int PT_W       = 5;
    localparam int WIN_W      = 16;

    // Slave identity layout: kind in the top two bits, address below
    localparam int ID_KIND_LSB = 9;
    localparam logic [ID_W-1:0] ID_BASE_BIT_OUT  = 11'h000;
    localparam logic [ID_W-1:0] ID_BASE_BIT_IN   = 11'h200;
    localparam logic [ID_W-1:0] ID_BASE_WORD_OUT = 11'h400;
    localparam logic [ID_W-1:0] ID_BASE_WORD_IN  = 11'h600;

    // Reserved addresses and alarm
    localparam logic [ADDR_W-1:0] RSV_ADDR_LOW  = 9'h0ff;
    localparam logic [ADDR_W-1:0] RSV_ADDR_HIGH = 9'h1ff;
    localparam logic [15:0]       ALARM_NO_ID   = 16'h0d91;

    // Least word point setting for reliable word storage
    localparam logic [9:0] WORD_POINTS_MIN = 10'h008;

    typedef enum logic [1:0] {
        KIND_BIT_OUT  = 2'h0,
        KIND_BIT_IN   = 2'h1,
        KIND_WORD_OUT = 2'h2,
        KIND_WORD_IN  = 2'h3
    } slave_kind_t;

    // One exchange with a slave: bit slaves move up to 16 points at once,
    // word slaves move one word, chosen by word_sel
    typedef struct packed {
        logic              valid;
        logic [ID_W-1:0]   id;
        logic [PT_W-1:0]   points;
        logic [3:0]        word_sel;
        logic [WIN_W-1:0]  data;
    } slave_xfer_t;

    typedef struct packed {
        logic              valid;
        logic              accepted;
        logic [WIN_W-1:0]  data;
    } slave_reply_t;

    typedef struct packed {
        logic              valid;
        logic [15:0]       code;
        logic [ID_W-1:0]   id;
    } alarm_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_AW-1:0] index;
        logic [WIN_W-1:0]  data;
    } host_word_wr_t;

endpackage

/* File: sim/remote_io_map_chk.sv */
// Port checker for the remote image mapper.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module remote_io_map_chk
    import remote_map_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_mode_1024,
    input  wire logic [9:0]           i_word_points,
    input  wire logic [BIT_IMAGE-1:0] i_remote_output_bits,
    input  wire logic [BIT_IMAGE-1:0] o_remote_input_bits,
    input  wire slave_xfer_t          i_xfer,
    input  wire slave_reply_t         o_reply,
    input  wire alarm_t               o_alarm,
    input  wire logic                 o_word_setting_low
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Address and kind of the exchange on the port
    wire logic [ADDR_W-1:0] x_addr = i_xfer.id[ADDR_W-1:0];
    wire logic              x_word = i_xfer.id[ID_W-1];
    wire logic              x_go   = i_xfer.valid;

    reply_pulse_a: assert property (x_go |=> o_reply.valid)
        else $error("reply missing");
    no_stray_a: assert property (!x_go |=> !o_reply.valid && !o_alarm.valid)
        else $error("stray reply");
    alarm_code_a: assert property (o_alarm.valid |-> o_alarm.code == ALARM_NO_ID
        && o_reply.valid && !o_reply.accepted) else $error("bad alarm");
    top_rsv_a: assert property (x_go && x_addr == RSV_ADDR_HIGH
        |=> o_alarm.valid && o_alarm.id == $past(i_xfer.id)) else $error("511 not refused");
    low_rsv_a: assert property (x_go && x_addr == RSV_ADDR_LOW && !x_word
        |=> o_alarm.valid == !$past(i_mode_1024)) else $error("255 handling");
    word_low_a: assert property ($past(i_rst_n)
        |-> o_word_setting_low == ($past(i_word_points) < WORD_POINTS_MIN)) else $error("low");
    word_refuse_a: assert property (x_go && x_word && i_word_points < WORD_POINTS_MIN
        |=> !o_reply.accepted && o_reply.data == 16'h0000) else $error("word taken");
    bit_out_a: assert property (x_go && i_xfer.id[10:9] == 2'h0 && i_xfer.points == 5'h1
        && x_addr < RSV_ADDR_LOW |=> o_reply.data
        == {15'h0, $past(i_remote_output_bits[x_addr])}) else $error("bit out");
    idle_hold_a: assert property (!x_go |=> $stable(o_remote_input_bits))
        else $error("image moved");
    cover property (o_alarm.valid);
    cover property (o_reply.valid && !o_reply.accepted && !o_alarm.valid);
    cover property (x_go && !x_word);
    cover property (x_go && x_word);
endmodule
bind remote_io_map remote_io_map_chk chk (.i_clk, .i_rst_n, .i_mode_1024, .i_word_points,
    .i_remote_output_bits, .o_remote_input_bits, .i_xfer, .o_reply, .o_alarm,
    .o_word_setting_low);
`default_nettype wire

/* File: sim/slave_model.sv */
// Model of the field-bus slaves facing the mapper.
// Assumes the bench commands one exchange at a time.
`timescale 1ns/100ps
`default_nettype none
module slave_model
    import remote_map_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_set,
    input  wire logic             i_go,
    input  wire logic [ID_W-1:0]  i_id,
    input  wire logic [PT_W-1:0]  i_points,
    input  wire logic [3:0]       i_word_sel,
    input  wire logic [WIN_W-1:0] i_data,
    output slave_xfer_t           o_xfer
);
    logic [ID_W-1:0] id;
    // Identity kept until a new one is written
    always_ff @(posedge i_clk) begin
        if (i_set) begin
            id <= i_id;
        end
    end
    // One exchange per command; idle lines show the inverse of the last value
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            o_xfer <= {1'b1, id, i_points, i_word_sel, i_data};
        end else begin
            o_xfer <= {1'b0, ~o_xfer[35:0]};
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the remote image mapper.
// Assumes a 10 MHz clock and the slave model on the exchange port.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import remote_map_pkg::*;
;
    logic            clk, rst_n, mode, set, go, wlow;
    logic [9:0]      wpts;
    logic [1023:0]   obits, ibits;
    logic [8:0]      rd_idx;
    logic [15:0]     rd_data, sdat;
    logic [10:0]     sid;
    logic [4:0]      spts;
    logic [3:0]      ssel;
    host_word_wr_t   hwr;
    slave_xfer_t     xfer;
    slave_reply_t    reply;
    alarm_t          alarm;
    int              mismatches, n_compared, cycles;

    remote_io_map dut (.i_clk(clk), .i_rst_n(rst_n), .i_mode_1024(mode),
        .i_word_points(wpts), .i_remote_output_bits(obits), .o_remote_input_bits(ibits),
        .i_host_word_wr(hwr), .i_host_rd_index(rd_idx), .o_host_rd_data(rd_data),
        .i_xfer(xfer), .o_reply(reply), .o_alarm(alarm), .o_word_setting_low(wlow));
    slave_model slaves (.i_clk(clk), .i_set(set), .i_go(go), .i_id(sid), .i_points(spts),
        .i_word_sel(ssel), .i_data(sdat), .o_xfer(xfer));

    task automatic check(input string what, input logic [1023:0] exp, input logic [1023:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Loads the slave identity, runs one exchange, returns in the reply cycle
    task automatic send(input logic [10:0] i, input logic [4:0] p, input logic [3:0] s,
                        input logic [15:0] d);
        sid = i;
        spts = p;
        ssel = s;
        sdat = d;
        set = 1'b1;
        @(posedge clk);
        #1 set = 1'b0;
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_bit_in;
        send(11'h200, 5'h02, 4'h0, 16'hffff);
        check("in reply", {2'b11, 16'h0}, reply);
        send(11'h203, 5'h02, 4'h0, 16'h0002);
        send(11'h202, 5'h01, 4'h0, 16'hffff);
        send(11'h211, 5'h01, 4'h0, 16'h0001);
        check("in bits", 1024'h20017, ibits);
    endtask
    task automatic t_bit_out;
        obits = 1024'h0c;
        send(11'h002, 5'h02, 4'h0, 16'h0);
        check("out 2", {2'b11, 16'h3}, reply);
        send(11'h002, 5'h01, 4'h0, 16'h0);
        check("out 2 one", {2'b11, 16'h1}, reply);
        send(11'h003, 5'h02, 4'h0, 16'h0);
        check("out 3", {2'b11, 16'h1}, reply);
    endtask
    task automatic t_word;
        hwr = '{1'b1, 9'h002, 16'h1234};
        @(posedge clk);
        #1 hwr = '{1'b1, 9'h003, 16'h5678};
        @(posedge clk);
        #1 hwr.valid = 1'b0;
        send(11'h402, 5'h0, 4'h0, 16'h0);
        check("word out 2", {2'b11, 16'h1234}, reply);
        send(11'h402, 5'h0, 4'h1, 16'h0);
        check("word out", {2'b11, 16'h5678}, reply);
        check("word low", 1'b0, wlow);
        send(11'h600, 5'h0, 4'h0, 16'hbeef);
        send(11'h600, 5'h0, 4'h1, 16'hcafe);
        rd_idx = 9'h000;
        @(posedge clk);
        #1 check("word in 0", 16'hbeef, rd_data);
        rd_idx = 9'h001;
        @(posedge clk);
        #1 check("word in", 16'hcafe, rd_data);
        wpts = 10'h007;
        send(11'h601, 5'h0, 4'h0, 16'h1111);
        check("word refused", {2'b10, 16'h0}, reply);
        check("word low", 1'b1, wlow);
        @(posedge clk);
        #1 check("word kept", 16'hcafe, rd_data);
        wpts = 10'h008;
    endtask
    task automatic t_rsv;
        logic hit;
        for (int n = 0; n < 16; n++) begin
            mode = n[0];
            hit = n[1] || (n[3] == 1'b0 && !n[0]);
            send({n[3:2], n[1] ? 9'h1ff : 9'h0ff}, 5'h01, 4'h0, 16'h0);
            check("alarm", hit, alarm.valid);
            check("accepted", !hit, reply.accepted);
            if (hit) begin
                check("alarm id", {ALARM_NO_ID, sid}, {alarm.code, alarm.id});
            end
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        mode = 1'b0;
        set = 1'b0;
        go = 1'b0;
        wpts = 10'h008;
        obits = '0;
        rd_idx = '0;
        hwr = '0;
        sid = '0;
        spts = '0;
        ssel = '0;
        sdat = '0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        check("reset bits", '0, ibits);
        t_bit_in();
        t_bit_out();
        t_word();
        t_rsv();
        close_out();
    end
endmodule
`default_nettype wire
